// >>> hw/event_sample_record_builder.v
`include "event_sample_map.vh"
`timescale 1ns/1ps
`default_nettype none
module event_sample_record_builder #(
   parameter NGP = 8,   // general counters, at most 8 reset slots
   parameter NFX = 4    // fixed counters, at most 4 reset slots
) (
   // clock and reset
   input  wire          clk_i,
   input  wire          rst_i,
   // classic wishbone slave
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [7:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o,
   // interrupt
   output reg           irq_o,
   // counter events from the core
   input  wire [NGP-1:0] gp_ovf_i,
   input  wire [NFX-1:0] fix_ovf_i,
   input  wire [NGP-1:0] gp_precise_i,
   input  wire          retire_i,
   input  wire [63:0]   retire_ip_i,
   // group data lookup
   output reg  [2:0]    grp_sel_o,
   output reg  [6:0]    grp_idx_o,
   input  wire [63:0]   grp_data_i,
   // record word stream
   output reg           rec_valid_o,
   output reg  [63:0]   rec_data_o,
   output reg           rec_last_o,
   input  wire          rec_ready_i,
   // counter reload
   output reg           reload_valid_o,
   output reg  [5:0]    reload_idx_o,
   output reg  [63:0]   reload_value_o
);
   localparam [1:0] S_IDLE  = 2'd0;   // waiting for a trigger
   localparam [1:0] S_EMIT  = 2'd1;   // producing record words
   localparam [1:0] S_DRAIN = 2'd2;   // last word waits for ready
   localparam       NSLOT   = NGP + NFX;
   localparam [31:0] GP_MASK  = ~(32'hffffffff << NGP);
   localparam [31:0] FIX_MASK = ~(32'hffffffff << NFX);
   localparam [NFX-1:0] FIX_PREC = 1;
   localparam [7:0] FIX_PAIR =
      (`OFF_FIX_RESET_BASE - `OFF_GP_RESET_BASE) >> 3;

   // software registers
   reg  [31:0]    sample_en_lo;   // general counter enables
   reg  [31:0]    sample_en_hi;   // fixed counter enables
   reg  [31:0]    group_sel;      // group selection and branch depth
   reg  [31:0]    gp_adapt;       // adaptive bit per general counter
   reg  [31:0]    fix_adapt;      // adaptive bit per fixed counter
   reg  [1:0]     status;         // sticky events
   reg  [1:0]     irq_mask;       // interrupt enables
   reg  [63:0]    tsc;            // free running time stamp
   reg  [63:0]    last_ip;        // most recent retired pointer
   // record capture
   reg  [1:0]     state;
   reg  [31:0]    cfg_cap;        // groups of this record
   reg  [63:0]    fmt_word;       // format and size word
   reg  [63:0]    ip_cap;
   reg  [63:0]    app_cap;
   reg  [63:0]    tsc_cap;
   reg  [NSLOT-1:0] reload_pend;  // counters still to reload
   // combinational helpers
   reg  [31:0]    rd_val;
   reg  [63:0]    cur_word;
   reg            pick_ok;
   reg  [3:0]     pick_slot;
   reg  [3:0]     pick_pair;
   reg  [5:0]     pick_pos;
   integer        s;
   integer        pos;            // scratch for fixed-slot arithmetic

   // byte lane mask from select lines
   function [31:0] lane;
      input [3:0] sl;
      begin
         lane = {{8{sl[3]}}, {8{sl[2]}}, {8{sl[1]}}, {8{sl[0]}}};
      end
   endfunction

   // merge written bytes into an old value
   function [31:0] merge;
      input [31:0] o;
      input [31:0] n;
      input [3:0]  sl;
      begin
         merge = (o & ~lane(sl)) | (n & lane(sl));
      end
   endfunction

   // words of one group under a selection
   function [6:0] grp_words;
      input [2:0]  g;
      input [31:0] c;
      begin
         case (g)
            `GRP_BASIC: grp_words = `WORDS_BASIC;
            `GRP_MEM:   grp_words = `WORDS_MEM;
            `GRP_GPR:   grp_words = `WORDS_GPR;
            `GRP_XMM:   grp_words = `WORDS_XMM;
            `GRP_LBR:   grp_words = `WORDS_LBR_ENTRY *
               ({2'b00, c[`GSEL_DEPTH_MSB:`GSEL_DEPTH_LSB]} + 7'h01);
            default:    grp_words = 7'h00;
         endcase
      end
   endfunction

   // next selected group after g, in fixed order, no gap for others
   function [2:0] next_grp;
      input [2:0]  g;
      input [31:0] c;
      integer k;
      begin
         next_grp = `GRP_END;
         for (k = 4; k >= 1; k = k - 1) begin
            if (k > g && c[k-1]) begin
               next_grp = k[2:0];
            end
         end
      end
   endfunction

   // whole record size in bytes
   function [15:0] rec_bytes;
      input [31:0] c;
      reg [12:0] w;
      begin
         w = {6'h00, `WORDS_BASIC};
         if (c[`GSEL_MEM]) w = w + {6'h00, grp_words(`GRP_MEM, c)};
         if (c[`GSEL_GPR]) w = w + {6'h00, grp_words(`GRP_GPR, c)};
         if (c[`GSEL_XMM]) w = w + {6'h00, grp_words(`GRP_XMM, c)};
         if (c[`GSEL_LBR]) w = w + {6'h00, grp_words(`GRP_LBR, c)};
         rec_bytes = {w, 3'b000};
      end
   endfunction

   // bus decode; one wait state, every address answered
   wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        bus_wr  = bus_req & wb_we_i;
   wire [31:0] wmask   = lane(wb_sel_i);
   wire [7:0]  moff    = wb_adr_i - `OFF_GP_RESET_BASE;
   wire        in_mem  = (wb_adr_i >= `OFF_GP_RESET_BASE) &&
                         (wb_adr_i < `OFF_RESET_END);
   wire [31:0] mem_rd;
   wire [63:0] pair_data;

   // overflow flags
   wire [NGP-1:0] gp_pend;
   wire [NFX-1:0] fix_pend;
   wire           gp_lost;
   wire           fix_lost;
   wire [31:0]    sw_lo = (bus_wr && wb_adr_i == `OFF_OVF_SET_LO) ?
                          (wb_dat_i & wmask) : 32'h0;
   wire [31:0]    sw_hi = (bus_wr && wb_adr_i == `OFF_OVF_SET_HI) ?
                          (wb_dat_i & wmask) : 32'h0;
   wire [NGP-1:0] gp_en  = sample_en_lo[NGP-1:0];
   wire [NFX-1:0] fix_en = sample_en_hi[NFX-1:0];

   // trigger selection
   wire [NGP-1:0] np_gp  = gp_pend & ~gp_precise_i;
   wire [NFX-1:0] np_fix = fix_pend & ~FIX_PREC;
   wire [NGP-1:0] p_gp   = gp_pend & gp_precise_i;
   wire [NFX-1:0] p_fix  = fix_pend & FIX_PREC;
   wire           fire_np = |np_gp | |np_fix;
   wire           fire_p  = retire_i & (|p_gp | |p_fix);
   // one record at a time; reloads finish before the next trigger
   wire           start  = (state == S_IDLE) && !(|reload_pend) &&
                           (fire_np || fire_p);
   wire [NGP-1:0] gp_take  = start ? (np_gp | (retire_i ? p_gp : {NGP{1'b0}}))
                                   : {NGP{1'b0}};
   wire [NFX-1:0] fix_take = start ? (np_fix | (retire_i ? p_fix : {NFX{1'b0}}))
                                   : {NFX{1'b0}};
   // adaptive when any triggering counter asks for it
   wire           adaptive = |(gp_take & gp_adapt[NGP-1:0]) |
                             |(fix_take & fix_adapt[NFX-1:0]);
   wire [31:0]    next_cfg = adaptive ? group_sel : 32'h0;
   wire [63:0]    next_app = {{(32-NFX){1'b0}}, fix_take,
                              {(32-NGP){1'b0}}, gp_take};

   // emission position
   wire [2:0]     nxt_grp  = next_grp(grp_sel_o, cfg_cap);
   wire [6:0]     idx_inc  = grp_idx_o + 7'h01;
   wire           more     = idx_inc < grp_words(grp_sel_o, cfg_cap);
   wire           is_last  = !more && (nxt_grp == `GRP_END);
   wire           load     = !rec_valid_o || rec_ready_i;
   wire           rec_done = (state == S_DRAIN) && rec_ready_i;
   wire [1:0]     st_clr   = (bus_wr && wb_adr_i == `OFF_STATUS) ?
                             (wb_dat_i[1:0] & wmask[1:0]) : 2'b00;
   wire [1:0]     st_set   = {gp_lost | fix_lost, rec_done};

   overflow_latch #(.W(NGP)) u_gp_flags (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (gp_ovf_i | sw_lo[NGP-1:0]),
      .en_i   (gp_en),
      .take_i (gp_take),
      .pend_o (gp_pend),
      .lost_o (gp_lost)
   );

   overflow_latch #(.W(NFX)) u_fix_flags (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (fix_ovf_i | sw_hi[NFX-1:0]),
      .en_i   (fix_en),
      .take_i (fix_take),
      .pend_o (fix_pend),
      .lost_o (fix_lost)
   );

   // reset values live here; software fills slots before enabling
   reset_value_mem #(.DEPTH(24), .AW(5)) u_reset_vals (
      .clk_i       (clk_i),
      .wr_i        (bus_wr && in_mem),
      .wr_addr_i   (moff[6:2]),
      .wr_be_i     (wb_sel_i),
      .wr_data_i   (wb_dat_i),
      .rd_addr_i   (moff[6:2]),
      .rd_data_o   (mem_rd),
      .pair_i      (pick_pair),
      .pair_data_o (pair_data)
   );

   // register read mux
   always @* begin
      rd_val = 32'h0;
      case (wb_adr_i)
         `OFF_SAMPLE_EN_LO: rd_val = sample_en_lo;
         `OFF_SAMPLE_EN_HI: rd_val = sample_en_hi;
         `OFF_GROUP_SEL:    rd_val = group_sel;
         `OFF_GP_ADAPT:     rd_val = gp_adapt;
         `OFF_FIX_ADAPT:    rd_val = fix_adapt;
         `OFF_OVF_SET_LO:   rd_val = {{(32-NGP){1'b0}}, gp_pend};
         `OFF_OVF_SET_HI:   rd_val = {{(32-NFX){1'b0}}, fix_pend};
         `OFF_STATUS:       rd_val = {30'h0, status};
         `OFF_MASK:         rd_val = {30'h0, irq_mask};
         `OFF_TSC_LO:       rd_val = tsc[31:0];
         `OFF_TSC_HI:       rd_val = tsc[63:32];
         default: begin
            if (in_mem) begin
               rd_val = mem_rd;           // unmapped offsets read zero
            end
         end
      endcase
   end

   // bus slave registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= `RST_REG;
         sample_en_lo <= `RST_REG;
         sample_en_hi <= `RST_REG;
         group_sel    <= `RST_REG;
         gp_adapt     <= `RST_REG;
         fix_adapt    <= `RST_REG;
         irq_mask     <= 2'b00;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_val : 32'h0;
         if (bus_wr) begin
            case (wb_adr_i)
               `OFF_SAMPLE_EN_LO:
                  sample_en_lo <= merge(sample_en_lo, wb_dat_i, wb_sel_i) & GP_MASK;
               `OFF_SAMPLE_EN_HI:
                  sample_en_hi <= merge(sample_en_hi, wb_dat_i, wb_sel_i) & FIX_MASK;
               `OFF_GROUP_SEL:
                  group_sel <= merge(group_sel, wb_dat_i, wb_sel_i) & `GSEL_WMASK;
               `OFF_GP_ADAPT:
                  gp_adapt <= merge(gp_adapt, wb_dat_i, wb_sel_i) & GP_MASK;
               `OFF_FIX_ADAPT:
                  fix_adapt <= merge(fix_adapt, wb_dat_i, wb_sel_i) & FIX_MASK;
               `OFF_MASK:
                  irq_mask <= wb_sel_i[0] ? wb_dat_i[1:0] : irq_mask;
               default: begin
                  irq_mask <= irq_mask;   // others are handled elsewhere
               end
            endcase
         end
      end
   end

   // sticky status, set wins over write-one-clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         status <= 2'b00;
         irq_o  <= 1'b0;
      end else begin
         status <= (status & ~st_clr) | st_set;
         irq_o  <= |(((status & ~st_clr) | st_set) & irq_mask);
      end
   end

   // time stamp and last retired pointer
   always @(posedge clk_i) begin
      if (rst_i) begin
         tsc     <= 64'h0;
         last_ip <= 64'h0;
      end else begin
         tsc <= tsc + 64'h1;
         if (retire_i) begin
            last_ip <= retire_ip_i;
         end
      end
   end

   // current word: basic fields from capture, other groups from the core
   always @* begin
      cur_word = grp_data_i;
      if (grp_sel_o == `GRP_BASIC) begin
         case (grp_idx_o)
            7'h00:   cur_word = fmt_word;
            7'h01:   cur_word = ip_cap;
            7'h02:   cur_word = app_cap;
            default: cur_word = tsc_cap;
         endcase
      end
   end

   // record sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         state       <= S_IDLE;
         cfg_cap     <= 32'h0;
         fmt_word    <= 64'h0;
         ip_cap      <= 64'h0;
         app_cap     <= 64'h0;
         tsc_cap     <= 64'h0;
         grp_sel_o   <= `GRP_BASIC;
         grp_idx_o   <= 7'h00;
         rec_valid_o <= 1'b0;
         rec_data_o  <= 64'h0;
         rec_last_o  <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (start) begin
                  state    <= S_EMIT;
                  cfg_cap  <= next_cfg;
                  fmt_word <= {rec_bytes(next_cfg),
                               16'h0, next_cfg};
                  // pointer of the instruction retiring now, else the last one
                  ip_cap   <= retire_i ? retire_ip_i : last_ip;
                  app_cap  <= next_app;
                  tsc_cap  <= tsc;
                  grp_sel_o <= `GRP_BASIC;
                  grp_idx_o <= 7'h00;
               end
            end
            S_EMIT: begin
               if (load) begin
                  rec_valid_o <= 1'b1;
                  rec_data_o  <= cur_word;
                  rec_last_o  <= is_last;
                  if (is_last) begin
                     state <= S_DRAIN;
                  end else if (more) begin
                     grp_idx_o <= idx_inc;
                  end else begin
                     grp_sel_o <= nxt_grp;
                     grp_idx_o <= 7'h00;
                  end
               end
            end
            S_DRAIN: begin
               if (rec_ready_i) begin
                  rec_valid_o <= 1'b0;
                  rec_last_o  <= 1'b0;
                  grp_sel_o   <= `GRP_BASIC;
                  grp_idx_o   <= 7'h00;
                  state       <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // pick the lowest counter still waiting for its reload
   always @* begin
      pick_ok   = 1'b0;
      pick_slot = 4'h0;
      pick_pair = 4'h0;
      pick_pos  = 6'h00;
      pos       = 0;
      for (s = NSLOT - 1; s >= 0; s = s - 1) begin
         if (reload_pend[s]) begin
            pick_ok   = 1'b1;
            pick_slot = s[3:0];
            if (s < NGP) begin
               pick_pair = s[3:0];
               pick_pos  = s[5:0];
            end else begin
               pos       = s - NGP;                 // fixed counter number
               pick_pair = FIX_PAIR[3:0] + pos[3:0];
               pos       = pos + `FIXED_BIT_BASE;   // enable-register layout
               pick_pos  = pos[5:0];
            end
         end
      end
   end

   // one reload per cycle from the reset-value slots
   always @(posedge clk_i) begin
      if (rst_i) begin
         reload_pend    <= {NSLOT{1'b0}};
         reload_valid_o <= 1'b0;
         reload_idx_o   <= 6'h00;
         reload_value_o <= 64'h0;
      end else begin
         reload_valid_o <= pick_ok;
         if (start) begin
            reload_pend <= {fix_take, gp_take};
         end else if (pick_ok) begin
            reload_pend[pick_slot] <= 1'b0;
            reload_idx_o   <= pick_pos;
            reload_value_o <= pair_data;
         end
      end
   end
endmodule // event_sample_record_builder
`default_nettype wire

// >>> pkg/event_sample_map.vh
`ifndef EVENT_SAMPLE_MAP_VH
`define EVENT_SAMPLE_MAP_VH
// register byte offsets on the wishbone slave
`define OFF_SAMPLE_EN_LO    8'h00
`define OFF_SAMPLE_EN_HI    8'h04
`define OFF_GROUP_SEL       8'h08
`define OFF_GP_ADAPT        8'h0c
`define OFF_FIX_ADAPT       8'h10
`define OFF_OVF_SET_LO      8'h14
`define OFF_OVF_SET_HI      8'h18
`define OFF_STATUS          8'h1c
`define OFF_MASK            8'h20
`define OFF_TSC_LO          8'h24
`define OFF_TSC_HI          8'h28
// reset-value area, one 64-bit slot per counter
`define OFF_GP_RESET_BASE   8'h40
`define OFF_FIX_RESET_BASE  8'h80
`define OFF_RESET_END       8'ha0
// enable and applicable-counter bit positions
`define GP_BIT_BASE         0
`define FIXED_BIT_BASE      32
// group select fields
`define GSEL_MEM            0
`define GSEL_GPR            1
`define GSEL_XMM            2
`define GSEL_LBR            3
`define GSEL_DEPTH_LSB      24
`define GSEL_DEPTH_MSB      28
`define GSEL_WMASK          32'h1f00000f
// record format word fields
`define FMT_CFG_MSB         47
`define FMT_SIZE_LSB        48
// status bits
`define ST_REC_DONE         0
`define ST_OVF_LOST         1
`define ST_WMASK            32'h00000003
// group identifiers in emission order
`define GRP_BASIC           3'h0
`define GRP_MEM             3'h1
`define GRP_GPR             3'h2
`define GRP_XMM             3'h3
`define GRP_LBR             3'h4
`define GRP_END             3'h7
// 64-bit words per group
`define WORDS_BASIC         7'h04
`define WORDS_MEM           7'h04
`define WORDS_GPR           7'h12
`define WORDS_XMM           7'h20
`define WORDS_LBR_ENTRY     7'h03
// register reset values
`define RST_REG             32'h00000000
`endif

// >>> hw/overflow_latch.v
`timescale 1ns/1ps
`default_nettype none
module overflow_latch #(
   parameter W = 8
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // per-counter controls
   input  wire [W-1:0] set_i,   // overflow seen this cycle
   input  wire [W-1:0] en_i,    // sampling enable
   input  wire [W-1:0] take_i,  // consumed by a record
   // state
   output wire [W-1:0] pend_o,  // overflow waiting for a record
   output wire         lost_o   // overflow on a counter already waiting
);
   wire [W-1:0] hit;            // enabled overflows only
   wire [W-1:0] pend;           // one flop per counter
   assign hit    = set_i & en_i;
   assign pend_o = pend;
   // a second overflow before the record is taken merges into one record
   assign lost_o = |(hit & pend & ~take_i);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_cnt
         reg flag;
         assign pend[i] = flag;
         // set wins over take so a fresh overflow is never dropped
         always @(posedge clk_i) begin
            if (rst_i) begin
               flag <= 1'b0;
            end else if (hit[i]) begin
               flag <= 1'b1;
            end else if (take_i[i] || !en_i[i]) begin
               flag <= 1'b0;      // disabling also drops a waiting overflow
            end
         end
      end
   endgenerate
endmodule // overflow_latch
`default_nettype wire

// >>> hw/reset_value_mem.v
`timescale 1ns/1ps
`default_nettype none
module reset_value_mem #(
   parameter DEPTH = 24,
   parameter AW    = 5
) (
   // clock
   input  wire          clk_i,
   // bus write port with byte enables
   input  wire          wr_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [3:0]    wr_be_i,
   input  wire [31:0]   wr_data_i,
   // bus read port
   input  wire [AW-1:0] rd_addr_i,
   output wire [31:0]   rd_data_o,
   // 64-bit read of one counter slot for the reload path
   input  wire [AW-2:0] pair_i,
   output wire [63:0]   pair_data_o
);
   reg [31:0] mem [0:DEPTH-1];  // no reset: software fills it before use
   integer b;

   // byte-lane write; the top guards the address range
   always @(posedge clk_i) begin
      if (wr_i) begin
         for (b = 0; b < 4; b = b + 1) begin
            if (wr_be_i[b]) begin
               mem[wr_addr_i][8*b +: 8] <= wr_data_i[8*b +: 8];
            end
         end
      end
   end

   assign rd_data_o   = mem[rd_addr_i];
   assign pair_data_o = {mem[{pair_i, 1'b1}], mem[{pair_i, 1'b0}]};
endmodule // reset_value_mem
`default_nettype wire

// >>> tb/esrb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module esrb_asserts #(parameter NGP = 8, parameter NFX = 4) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // bus and streams
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rec_valid_o,
   input wire logic [63:0] rec_data_o,
   input wire logic        rec_last_o,
   input wire logic        rec_ready_i,
   input wire logic        reload_valid_o,
   input wire logic [5:0]  reload_idx_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic first; // next accepted word opens a record
   always_ff @(posedge clk_i)
      if (rst_i) first <= 1'b1;
      else if (rec_valid_o && rec_ready_i) first <= rec_last_o;
   // record bytes implied by the format word
   function automatic logic [15:0] bytes(input logic [31:0] c);
      bytes = 16'(8 * (4 + 4*c[0] + 18*c[1] + 32*c[2] + (c[3] ? 3*(c[28:24]+1) : 0)));
   endfunction
   property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack late");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_word_hold; rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_data_o); endproperty
   a_word_hold: assert property (p_word_hold) else $error("word dropped");
   property p_last_drop; rec_valid_o && rec_ready_i && rec_last_o |=> !rec_valid_o; endproperty
   a_last_drop: assert property (p_last_drop) else $error("valid after last");
   property p_fmt_zero; first && rec_valid_o |-> rec_data_o[47:32] == 16'h0; endproperty
   a_fmt_zero: assert property (p_fmt_zero) else $error("format bits set");
   property p_fmt_size; first && rec_valid_o |-> rec_data_o[63:48] == bytes(rec_data_o[31:0]); endproperty
   a_fmt_size: assert property (p_fmt_size) else $error("record size wrong");
   property p_reload_first; $rose(rec_valid_o) |-> reload_valid_o; endproperty
   a_reload_first: assert property (p_reload_first) else $error("no reload");
   property p_reload_idx; reload_valid_o |-> reload_idx_o < NGP || reload_idx_o - 32 < NFX; endproperty
   a_reload_idx: assert property (p_reload_idx) else $error("reload position");
endmodule // esrb_asserts
bind event_sample_record_builder esrb_asserts #(.NGP(NGP), .NFX(NFX)) chk (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .rec_valid_o, .rec_data_o, .rec_last_o,
   .rec_ready_i, .reload_valid_o, .reload_idx_o);
`default_nettype wire

// >>> tb/record_sink.sv
`timescale 1ns/1ps
`default_nettype none
module record_sink (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // group lookup
   input  wire logic [2:0]  sel_i,
   input  wire logic [6:0]  idx_i,
   output logic      [63:0] data_o,
   // record stream
   input  wire logic        valid_i,
   input  wire logic [63:0] word_i,
   input  wire logic        last_i,
   output logic             ready_o = 1'b0,
   // slow memory when high
   input  wire logic        stall_i
);
   logic [63:0] w[$]; // stored words
   int nrec = 0;       // complete records
   int tick = 0;
   // words carry group and index so packing order is visible
   assign data_o = {32'h5a5a0000, 22'h0, sel_i, idx_i};
   // slow mode accepts one cycle in three
   always @(posedge clk_i) begin
      tick <= tick + 1;
      ready_o <= !rst_i && (!stall_i || tick % 3 == 0);
      if (valid_i && ready_o) begin
         w.push_back(word_i);
         if (last_i) nrec <= nrec + 1;
      end
   end
endmodule // record_sink
`default_nettype wire

// >>> tb/event_sample_record_builder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module event_sample_record_builder_tb;
   logic        clk_i = 0, rst_i = 1, req = 0, wb_we_i = 0, retire_i = 0, stall = 0;
   logic [7:0]  wb_adr_i = '0, gp_ovf_i = '0, gp_precise_i = '0;
   logic [3:0]  fix_ovf_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, q;
   logic [63:0] retire_ip_i = '0, rec_data_o, grp_data_i, reload_value_o;
   logic        wb_ack_o, irq_o, rec_valid_o, rec_last_o, rec_ready_i, reload_valid_o;
   logic [2:0]  grp_sel_o;
   logic [6:0]  grp_idx_o;
   logic [5:0]  reload_idx_o;
   logic [69:0] rl[$]; // reloads seen
   int n_mismatch = 0, checks_done = 0;
   event_sample_record_builder dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .gp_ovf_i,
      .fix_ovf_i, .gp_precise_i, .retire_i, .retire_ip_i, .grp_sel_o, .grp_idx_o, .grp_data_i,
      .rec_valid_o, .rec_data_o, .rec_last_o, .rec_ready_i, .reload_valid_o, .reload_idx_o,
      .reload_value_o);
   record_sink sink (.clk_i, .rst_i, .sel_i(grp_sel_o), .idx_i(grp_idx_o), .data_o(grp_data_i),
      .valid_i(rec_valid_o), .word_i(rec_data_o), .last_i(rec_last_o), .ready_o(rec_ready_i),
      .stall_i(stall));
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (reload_valid_o) rl.push_back({reload_idx_o, reload_value_o});
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
      q = wb_dat_o;
      `CHK(wb_ack_o, 1'b1)
      req <= 1'b0;
   endtask
   // one-cycle event pulses
   task automatic pulse(input logic [7:0] g, input logic [3:0] f, input logic r);
      @(posedge clk_i);
      gp_ovf_i <= g;
      fix_ovf_i <= f;
      retire_i <= r;
      @(posedge clk_i);
      gp_ovf_i <= '0;
      fix_ovf_i <= '0;
      retire_i <= 1'b0;
   endtask
   // bounded wait for one more stored record, then let irq settle
   task automatic wrec();
      int k, n;
      k = sink.nrec;
      n = 0;
      while (sink.nrec == k && n++ < 500) @(posedge clk_i);
      `CHK(sink.nrec, k + 1)
      repeat (3) @(posedge clk_i);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1, 8'h50, 32'h11112222);
      wb(1, 8'h54, 32'h0);
      wb(1, 8'h80, 32'h33334444);
      wb(1, 8'h84, 32'h0);
      wb(0, 8'h50, 0);
      `CHK(q, 32'h11112222)
      wb(0, 8'h30, 0);
      `CHK(q, 32'h0)
      wb(1, 8'h20, 1);
      wb(1, 8'h00, 4);
      wb(1, 8'h14, 4);
      wrec();
      `CHK(sink.w[0], {16'h0020, 48'h0})
      `CHK(sink.w[2], 64'h4)
      `CHK(rl[0], {6'd2, 64'h11112222})
      `CHK(irq_o, 1'b1)
      wb(1, 8'h20, 0);
      @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      wb(1, 8'h1c, 1);
      wb(0, 8'h1c, 0);
      `CHK(q, 32'h0)
      // disabled counter and precise counter waiting for retire
      wb(1, 8'h04, 1);
      sink.w.delete();
      rl.delete();
      retire_ip_i <= 64'hfeed0000c0de0040;
      gp_precise_i <= 8'h04;
      pulse(8'h24, 4'h1, 0);
      repeat (10) @(posedge clk_i);
      `CHK(sink.w.size(), 0)
      pulse(0, 0, 1);
      wrec();
      `CHK(sink.w[1], 64'hfeed0000c0de0040)
      `CHK(sink.w[2], 64'h100000004)
      `CHK(rl.size(), 2)
      `CHK(rl[0], {6'd2, 64'h11112222})
      `CHK(rl[1], {6'd32, 64'h33334444})
      // adaptive record into a stalling memory
      wb(1, 8'h08, 32'h0100000b);
      wb(1, 8'h0c, 4);
      gp_precise_i <= '0;
      wb(0, 8'h24, 0);
      sink.w.delete();
      stall <= 1'b1;
      pulse(8'h04, 0, 0);
      wrec();
      `CHK(sink.w.size(), 32)
      `CHK(sink.w[1], 64'hfeed0000c0de0040)
      `CHK(sink.w[3], {32'h0, q + 32'h4})
      `CHK(sink.w[0], {16'h0100, 16'h0, 32'h0100000b})
      `CHK(sink.w[4], {32'h5a5a0000, 22'h0, 3'h1, 7'h0})
      `CHK(sink.w[8], {32'h5a5a0000, 22'h0, 3'h2, 7'h0})
      `CHK(sink.w[31], {32'h5a5a0000, 22'h0, 3'h4, 7'h5})
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule // event_sample_record_builder_tb
`default_nettype wire
